/* File: hw/sdrisr_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module sdrisr_ctrl
	import sdrisr_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] modeWord,
	input wire logic burstRefresh,
	input wire logic srEnterReq,
	input wire logic srExitReq,
	output logic ready,
	output logic initDone,
	output logic inSelfRefresh,
	output logic memClkRun,
	output logic memCke,
	output logic memCsN,
	output logic memRasN,
	output logic memCasN,
	output logic memWeN,
	output logic [BA_W-1:0] memBa,
	output logic [ADDR_W-1:0] memAddr,
	output logic [DQM_W-1:0] memDqm
);
	sdrisr_state_t state;
	sdrisr_state_t next_state;
	sdrisr_cmd_t next_cmd;
	logic [TIMER_W-1:0] refCnt;
	logic [TIMER_W-1:0] next_refCnt;
	logic enterPend;
	logic exitPend;
	logic timerLoad;
	logic [TIMER_W-1:0] timerVal;
	logic next_cke;
	logic next_clkRun;
	logic [ADDR_W-1:0] next_addr;
	wire logic timerDone;
	wire logic encCsN;
	wire logic encRasN;
	wire logic encCasN;
	wire logic encWeN;
	wire logic refLast;
	wire logic burstLast;
	wire logic srStates;
	wire logic initPhase;
	wire logic nextIdle;
	wire logic enterServed;
	wire logic exitServed;
	wire logic initEnd;

	sdrisr_timer u_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.load(timerLoad),
		.loadVal(timerVal),
		.done(timerDone)
	);

	sdrisr_cmd_enc u_enc (
		.cmd(next_cmd),
		.csN(encCsN),
		.rasN(encRasN),
		.casN(encCasN),
		.weN(encWeN)
	);

	// refCnt counts refreshes already issued in the current run
	assign refLast = (refCnt == TIMER_W'(INIT_AREF_NUM - 1));
	assign burstLast = (refCnt == TIMER_W'(BURST_AREF_NUM - 1));
	assign srStates = (state == ST_SR_ENTER) || (state == ST_SR_HOLD) ||
		(state == ST_SR_CLKUP);
	assign initPhase = (state == ST_PWRUP) || (state == ST_PREALL) ||
		(state == ST_WAIT_RP) || (state == ST_MRS) || (state == ST_WAIT_RSC) ||
		(state == ST_INIT_AREF) || (state == ST_INIT_RFC);
	assign nextIdle = (next_state == ST_IDLE);
	// a request arriving in the cycle it is served stays pending: set wins
	assign enterServed = (next_state == ST_SR_ENTER);
	assign exitServed = (next_state == ST_SR_CLKUP);
	assign initEnd = initPhase && nextIdle;

	always_comb begin
		next_state = state;
		next_cmd = CMD_NO_OPERATION;
		next_refCnt = refCnt;
		timerLoad = 1'b0;
		timerVal = '0;
		next_cke = 1'b1;
		next_clkRun = 1'b1;
		next_addr = '0;
		case (state)
			ST_PWRUP: begin
				// timer already runs the pause from reset
				if (timerDone) begin
					next_state = ST_PREALL;
				end
			end
			ST_PREALL: begin
				next_cmd = CMD_PRECHARGE_ALL;
				next_addr[PRE_ALL_BIT] = 1'b1;
				timerLoad = 1'b1;
				timerVal = TIMER_W'(TRP_CYC - 1);
				next_state = ST_WAIT_RP;
			end
			ST_WAIT_RP: begin
				if (timerDone) begin
					next_state = ST_MRS;
				end
			end
			ST_MRS: begin
				next_cmd = CMD_MODE_SET;
				next_addr = modeWord;
				timerLoad = 1'b1;
				timerVal = TIMER_W'(TRSC_CYC - 1);
				next_state = ST_WAIT_RSC;
			end
			ST_WAIT_RSC: begin
				if (timerDone) begin
					next_refCnt = '0;
					next_state = ST_INIT_AREF;
				end
			end
			ST_INIT_AREF: begin
				next_cmd = CMD_AUTO_REFRESH;
				timerLoad = 1'b1;
				timerVal = TIMER_W'(TRFC_CYC - 1);
				next_state = ST_INIT_RFC;
			end
			ST_INIT_RFC: begin
				if (timerDone) begin
					if (refLast) begin
						next_state = ST_IDLE;
					end else begin
						next_refCnt = refCnt + 1'b1;
						next_state = ST_INIT_AREF;
					end
				end
			end
			ST_IDLE: begin
				if (enterPend) begin
					next_refCnt = '0;
					next_state = burstRefresh ? ST_PRE_AREF : ST_SR_ENTER;
				end
			end
			ST_PRE_AREF: begin
				next_cmd = CMD_AUTO_REFRESH;
				timerLoad = 1'b1;
				timerVal = TIMER_W'(TRFC_CYC - 1);
				next_state = ST_PRE_RFC;
			end
			ST_PRE_RFC: begin
				if (timerDone) begin
					if (burstLast) begin
						next_state = ST_SR_ENTER;
					end else begin
						next_refCnt = refCnt + 1'b1;
						next_state = ST_PRE_AREF;
					end
				end
			end
			ST_SR_ENTER: begin
				// select, row and column strobes low, write strobe high, and cke low in the same cycle
				next_cmd = CMD_SELF_REFRESH;
				next_cke = 1'b0;
				timerLoad = 1'b1;
				timerVal = TIMER_W'(TRAS_CYC - 1);
				next_state = ST_SR_HOLD;
			end
			ST_SR_HOLD: begin
				// memory listens only to cke now, so the clock may stop
				next_cke = 1'b0;
				next_clkRun = 1'b0;
				next_cmd = CMD_DESELECT;
				if (timerDone && exitPend) begin
					// gate opens now, else the clock runs one cycle short before cke
					next_clkRun = 1'b1;
					timerLoad = 1'b1;
					timerVal = TIMER_W'(CLK_STABLE_CYC - 1);
					next_state = ST_SR_CLKUP;
				end
			end
			ST_SR_CLKUP: begin
				// clock runs again while cke is still low
				next_cke = 1'b0;
				next_cmd = CMD_DESELECT;
				if (timerDone) begin
					next_cke = 1'b1;
					timerLoad = 1'b1;
					timerVal = TIMER_W'(SRX_CYC - 1);
					next_state = ST_SR_EXIT;
				end
			end
			ST_SR_EXIT: begin
				// deselect keeps the memory quiet for the whole exit time
				next_cmd = CMD_DESELECT;
				if (timerDone) begin
					next_refCnt = '0;
					next_state = burstRefresh ? ST_POST_AREF : ST_IDLE;
				end
			end
			ST_POST_AREF: begin
				next_cmd = CMD_AUTO_REFRESH;
				timerLoad = 1'b1;
				timerVal = TIMER_W'(TRFC_CYC - 1);
				next_state = ST_POST_RFC;
			end
			ST_POST_RFC: begin
				if (timerDone) begin
					if (burstLast) begin
						next_state = ST_IDLE;
					end else begin
						next_refCnt = refCnt + 1'b1;
						next_state = ST_POST_AREF;
					end
				end
			end
			default: begin
				next_state = ST_PWRUP;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_PWRUP;
			refCnt <= '0;
		end else begin
			state <= next_state;
			refCnt <= next_refCnt;
		end
	end

	// requests are held until served; an exit request before entry is kept
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			enterPend <= 1'b0;
			exitPend <= 1'b0;
		end else begin
			enterPend <= srEnterReq || (enterPend && !enterServed);
			exitPend <= srExitReq || (exitPend && !exitServed);
		end
	end

	// pins idle at no-operation, cke high and mask high from reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			memCke <= 1'b1;
			memClkRun <= 1'b1;
			memCsN <= 1'b0;
			memRasN <= 1'b1;
			memCasN <= 1'b1;
			memWeN <= 1'b1;
			memBa <= '0;
			memAddr <= '0;
			memDqm <= DQM_MASKED;
		end else begin
			memCke <= next_cke;
			memClkRun <= next_clkRun;
			memCsN <= encCsN;
			memRasN <= encRasN;
			memCasN <= encCasN;
			memWeN <= encWeN;
			memBa <= '0;
			memAddr <= next_addr;
			// no data traffic here, so keep outputs masked whenever the next state is not idle
			memDqm <= nextIdle ? DQM_OPEN : DQM_MASKED;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ready <= 1'b0;
			initDone <= 1'b0;
			inSelfRefresh <= 1'b0;
		end else begin
			ready <= nextIdle;
			// sticky: a self refresh round trip does not repeat init
			initDone <= initDone || initEnd;
			inSelfRefresh <= srStates;
		end
	end
endmodule : sdrisr_ctrl
`default_nettype wire

/* File: hw/sdrisr_pkg.sv */
package sdrisr_pkg;
	localparam int CLK_MHZ = 10;
	localparam int TIMER_W = 12;
	localparam int ADDR_W = 13;
	localparam int BA_W = 2;
	localparam int DQM_W = 2;
	// times in their own units
	localparam int PWRUP_US = 200;
	localparam int TRP_NS = 20;
	localparam int TRSC_NS = 14;
	localparam int TRFC_NS = 70;
	localparam int TRAS_NS = 45;
	localparam int TRC_NS = 63;
	localparam int TSRX_NS = 14;
	localparam int CLK_STABLE_NS = 300;
	// least times round up, never below one cycle
	function automatic int cyc_of(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : cyc_of
	localparam int PWRUP_CYC = cyc_of(PWRUP_US * 1000);
	localparam int TRP_CYC = cyc_of(TRP_NS);
	localparam int TRSC_CYC = cyc_of(TRSC_NS);
	localparam int TRFC_CYC = cyc_of(TRFC_NS);
	localparam int TRAS_CYC = cyc_of(TRAS_NS);
	localparam int TRC_CYC = cyc_of(TRC_NS);
	localparam int TSRX_CYC = cyc_of(TSRX_NS);
	localparam int CLK_STABLE_CYC = cyc_of(CLK_STABLE_NS);
	localparam int SRX_CYC = (TRC_CYC > TSRX_CYC) ? TRC_CYC : TSRX_CYC;
	localparam int INIT_AREF_NUM = 2;
	localparam int BURST_AREF_NUM = 2048;
	localparam int PRE_ALL_BIT = 10;
	localparam logic [DQM_W-1:0] DQM_MASKED = 2'h3;
	localparam logic [DQM_W-1:0] DQM_OPEN = 2'h0;

	typedef enum logic [2:0] {
		CMD_NO_OPERATION = 3'h0,
		CMD_DESELECT = 3'h1,
		CMD_PRECHARGE_ALL = 3'h2,
		CMD_MODE_SET = 3'h3,
		CMD_AUTO_REFRESH = 3'h4,
		CMD_SELF_REFRESH = 3'h5
	} sdrisr_cmd_t;

	typedef enum logic [3:0] {
		ST_PWRUP = 4'h0,
		ST_PREALL = 4'h1,
		ST_WAIT_RP = 4'h3,
		ST_MRS = 4'h2,
		ST_WAIT_RSC = 4'h6,
		ST_INIT_AREF = 4'h7,
		ST_INIT_RFC = 4'h5,
		ST_IDLE = 4'h4,
		ST_PRE_AREF = 4'hc,
		ST_PRE_RFC = 4'hd,
		ST_SR_ENTER = 4'hf,
		ST_SR_HOLD = 4'he,
		ST_SR_CLKUP = 4'ha,
		ST_SR_EXIT = 4'hb,
		ST_POST_AREF = 4'h9,
		ST_POST_RFC = 4'h8
	} sdrisr_state_t;
endpackage : sdrisr_pkg

/* File: hw/sdrisr_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module sdrisr_timer
	import sdrisr_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [TIMER_W-1:0] loadVal,
	output logic done
);
	logic [TIMER_W-1:0] cnt;
	wire logic [TIMER_W-1:0] next_cnt;

	// counting starts at reset so the power-up pause needs no command
	assign next_cnt = load ? loadVal : ((cnt == '0) ? cnt : cnt - 1'b1);
	// done ignores load: callers load on done, which would otherwise close a loop
	assign done = (cnt == '0);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= TIMER_W'(PWRUP_CYC - 1);
		end else begin
			cnt <= next_cnt;
		end
	end
endmodule : sdrisr_timer
`default_nettype wire

/* File: hw/sdrisr_cmd_enc.sv */
`timescale 1ns/100ps
`default_nettype none
module sdrisr_cmd_enc
	import sdrisr_pkg::*;
(
	input wire sdrisr_cmd_t cmd,
	output logic csN,
	output logic rasN,
	output logic casN,
	output logic weN
);
	logic [3:0] pins;

	always_comb begin
		case (cmd)
			CMD_NO_OPERATION: pins = 4'h7;
			CMD_DESELECT: pins = 4'hf;
			CMD_PRECHARGE_ALL: pins = 4'h2;
			CMD_MODE_SET: pins = 4'h0;
			CMD_AUTO_REFRESH: pins = 4'h1;
			// write strobe high tells self refresh apart from mode set
			CMD_SELF_REFRESH: pins = 4'h1;
			default: pins = 4'hf;
		endcase
	end

	assign csN = pins[3];
	assign rasN = pins[2];
	assign casN = pins[1];
	assign weN = pins[0];
endmodule : sdrisr_cmd_enc
`default_nettype wire

/* File: test/sdrisr_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sdrisr_mem_model
	import sdrisr_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clkRun,
	input wire logic cke,
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic [ADDR_W-1:0] addr,
	output logic [ADDR_W-1:0] modeReg,
	output logic inSr,
	output int unsigned arefCnt,
	output int unsigned errCnt
);
	wire logic pre = !csN && !rasN && casN && !weN;
	wire logic mrs = !csN && !rasN && !casN && !weN;
	wire logic aref = !csN && !rasN && !casN && weN;
	wire logic isCmd = !csN && !(rasN && casN && weN);
	int unsigned upCyc, srCyc, runCyc, sinceCke;
	logic preDone, mrsDone;
	// errors survive reset so a mid-run power cycle cannot hide them
	initial errCnt = 0;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			{preDone, mrsDone, inSr} <= '0;
			upCyc <= 0;
			arefCnt <= 0;
			sinceCke <= TRC_CYC + 1;
			modeReg <= '0;
		end else if (inSr) begin
			srCyc <= srCyc + 1;
			runCyc <= clkRun ? runCyc + 1 : 0;
			if (cke) begin
				inSr <= 1'b0;
				sinceCke <= 0;
				if (srCyc < TRAS_CYC || runCyc < CLK_STABLE_CYC || !clkRun)
					errCnt <= errCnt + 1;
			end
		end else begin
			upCyc <= upCyc + 1;
			sinceCke <= sinceCke + 1;
			if ((isCmd && (upCyc < PWRUP_CYC - 1 || sinceCke < TRC_CYC))
					|| (!cke && !aref) || !clkRun || (pre && !addr[PRE_ALL_BIT])
					|| (mrs && !preDone) || (aref && !mrsDone))
				errCnt <= errCnt + 1;
			if (pre)
				preDone <= 1'b1;
			if (mrs) begin
				modeReg <= addr;
				mrsDone <= 1'b1;
			end
			if (aref && cke)
				arefCnt <= arefCnt + 1;
			if (aref && !cke) begin
				inSr <= 1'b1;
				srCyc <= 0;
				runCyc <= 0;
			end
		end
	end
endmodule : sdrisr_mem_model
`default_nettype wire

/* File: test/sdrisr_ctrl_props.sv */
`timescale 1ns/100ps
`default_nettype none
module sdrisr_ctrl_props
	import sdrisr_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] modeWord,
	input wire logic initDone,
	input wire logic memClkRun,
	input wire logic memCke,
	input wire logic memCsN,
	input wire logic memRasN,
	input wire logic memCasN,
	input wire logic memWeN,
	input wire logic [ADDR_W-1:0] memAddr,
	input wire logic [DQM_W-1:0] memDqm
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [TIMER_W-1:0] upCyc;
	logic [TIMER_W-1:0] sinceRef;
	logic [TIMER_W-1:0] lowCyc;
	wire logic cmdNop = !memCsN && memRasN && memCasN && memWeN;
	wire logic cmdPre = !memCsN && !memRasN && memCasN && !memWeN;
	wire logic cmdMrs = !memCsN && !memRasN && !memCasN && !memWeN;
	wire logic cmdRef = !memCsN && !memRasN && !memCasN && memWeN;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			upCyc <= '0;
		else if (upCyc != '1)
			upCyc <= upCyc + 1'b1;
	end
	// cycles since the last refresh-type command, saturating
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			sinceRef <= '1;
		else if (cmdRef)
			sinceRef <= '0;
		else if (sinceRef != '1)
			sinceRef <= sinceRef + 1'b1;
	end
	// length of the current run of cke low
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			lowCyc <= '0;
		else if (memCke)
			lowCyc <= '0;
		else if (lowCyc != '1)
			lowCyc <= lowCyc + 1'b1;
	end
	pwrup_nop_a: assert property (upCyc < PWRUP_CYC - 1 |-> cmdNop && memCke && memClkRun)
		else $error("command during power-up pause");
	dqm_masked_a: assert property (!initDone |-> memDqm == DQM_MASKED)
		else $error("mask low before init done");
	pre_all_a: assert property (cmdPre |-> memAddr[PRE_ALL_BIT])
		else $error("precharge not all banks");
	mode_word_a: assert property (cmdMrs |-> memAddr == modeWord)
		else $error("mode word not on address");
	aref_gap_a: assert property (cmdRef && memCke |-> sinceRef >= TRFC_CYC)
		else $error("refreshes too close");
	sr_entry_a: assert property ($fell(memCke) |-> cmdRef)
		else $error("cke fell without self refresh command");
	sr_quiet_a: assert property (!memCke && !$past(memCke) |-> memCsN)
		else $error("memory selected in self refresh");
	clk_stable_a: assert property ($rose(memCke) |-> $past(memClkRun) &&
		$past(memClkRun, 2) && $past(memClkRun, 3))
		else $error("cke rose on unstable clock");
	sr_min_a: assert property ($rose(memCke) |-> lowCyc >= TRAS_CYC + CLK_STABLE_CYC)
		else $error("self refresh left too soon");
	exit_desel_a: assert property ($rose(memCke) |-> (memCke && memCsN) [*2])
		else $error("exit not deselected with cke high");
endmodule : sdrisr_ctrl_props
bind sdrisr_ctrl sdrisr_ctrl_props u_props(.clk, .sys_rst, .modeWord, .initDone, .memClkRun,
	.memCke, .memCsN, .memRasN, .memCasN, .memWeN, .memAddr, .memDqm);
`default_nettype wire

/* File: test/sdrisr_ctrl_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module sdrisr_ctrl_tb_top
	import sdrisr_pkg::*;
;
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	logic [ADDR_W-1:0] modeWord = '0;
	logic burstRefresh = 1'b0;
	logic srEnterReq = 1'b0;
	logic srExitReq = 1'b0;
	logic ready, initDone, inSelfRefresh, memClkRun, memCke, memCsN, memRasN, memCasN, memWeN;
	logic srMem;
	logic [BA_W-1:0] memBa;
	logic [ADDR_W-1:0] memAddr, modeReg;
	logic [DQM_W-1:0] memDqm;
	logic [31:0] rng = 32'h00010f04;
	int unsigned arefCnt, errCnt, a0, i, nMismatch = 0, nTests = 0;
	always #50 clk = ~clk;
	sdrisr_ctrl u_dut(.clk, .sys_rst(sysRst), .modeWord, .burstRefresh, .srEnterReq, .srExitReq,
		.ready, .initDone, .inSelfRefresh, .memClkRun, .memCke, .memCsN, .memRasN, .memCasN,
		.memWeN, .memBa, .memAddr, .memDqm);
	sdrisr_mem_model u_mem(.clk, .rst(sysRst), .clkRun(memClkRun), .cke(memCke), .csN(memCsN),
		.rasN(memRasN), .casN(memCasN), .weN(memWeN), .addr(memAddr), .modeReg, .inSr(srMem),
		.arefCnt, .errCnt);
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	function automatic int unsigned burst_refreshes(input logic burst);
		return burst ? BURST_AREF_NUM : 0;
	endfunction : burst_refreshes
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			nMismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		if (nMismatch == 0 && nTests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	task automatic pulse(input logic enter);
		@(negedge clk);
		if (enter)
			srEnterReq = 1'b1;
		else
			srExitReq = 1'b1;
		@(negedge clk);
		{srEnterReq, srExitReq} = 2'b00;
	endtask : pulse
	task automatic do_init();
		@(negedge clk);
		sysRst = 1'b1;
		rng = xs(rng);
		modeWord = rng[ADDR_W-1:0];
		repeat (16) @(negedge clk);
		check("ckeInReset", memCke, 1'b1);
		check("dqmInReset", memDqm, DQM_MASKED);
		sysRst = 1'b0;
		for (i = 0; i < 3000 && initDone !== 1'b1; i++)
			@(negedge clk);
		check("initDone", initDone, 1'b1);
		check("bankAddr", memBa, 2'h0);
		check("pauseLength", i >= PWRUP_CYC, 1'b1);
		check("modeReg", modeReg, modeWord);
		check("initRefreshes", arefCnt >= INIT_AREF_NUM, 1'b1);
	endtask : do_init
	// gap 0 is the awkward case: exit asked as soon as the memory model reports self refresh
	task automatic do_sr(input logic burst, input int gap);
		burstRefresh = burst;
		a0 = arefCnt;
		pulse(1'b1);
		for (i = 0; i < 20000 && srMem !== 1'b1; i++)
			@(negedge clk);
		check("srEntered", srMem, 1'b1);
		check("entryRefreshes", arefCnt - a0, burst_refreshes(burst));
		repeat (gap) @(negedge clk);
		check("inSelfRefresh", inSelfRefresh, 1'b1);
		a0 = arefCnt;
		pulse(1'b0);
		for (i = 0; i < 20000 && ready !== 1'b1; i++)
			@(negedge clk);
		check("readyBack", ready, 1'b1);
		check("srLeft", srMem, 1'b0);
		check("exitRefreshes", arefCnt - a0, burst_refreshes(burst));
	endtask : do_sr
	initial begin
		repeat (60000) @(posedge clk);
		nMismatch++;
		report_and_stop();
	end
	initial begin
		do_init();
		do_sr(1'b0, 0);
		do_sr(1'b1, 2);
		repeat (3) begin
			rng = xs(rng);
			do_sr(1'b0, int'(rng[3:0]));
		end
		pulse(1'b1);
		repeat (8) @(negedge clk);
		do_init();
		check("protocolErrors", errCnt, 0);
		report_and_stop();
	end
endmodule : sdrisr_ctrl_tb_top
`default_nettype wire
